// ==== common/cbp_pkg.sv ====
// Shared constants and types for the card bus command, byte-enable and parity logic
//
// Behaviour
// (RULE1) Address phase: command/byte-enable lines carry the initiator's bus command.
// (RULE2) Data phase: the same four lines carry the initiator's active byte enables.
// (RULE3) Byte enable bit n qualifies byte lane n of the 32-bit address/data bus.
// (RULE4) Even parity is computed over address/data and command/byte-enable lines every cycle.
// (RULE5) As initiator, the parity line follows the covered address or data by one card clock.
// (RULE6) As target, computed parity is compared with the initiator's parity line.
// (RULE7) A parity mismatch as target sets a sticky, readable parity-error indication.
`default_nettype none
package cbp_pkg;
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int LANE_W = 8;
  // Command bit that marks a write; the other commands are treated as reads
  localparam int CMD_DIR_BIT = 0;
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] CBE_RST = 4'h0;
  localparam logic PAR_RST = 1'b0;
  localparam logic FRAME_N_RST = 1'b1;
  // Card clock periods between a driven phase and its parity bit
  localparam int PAR_DELAY = 1;
  typedef enum logic [2:0] {INI_IDLE, INI_ADDR, INI_DATA, INI_PAR} cbp_ini_type;
endpackage
`default_nettype wire

// ==== hw/cbp_parity.sv ====
// Even parity over one address/data word and its command/byte-enable group
`default_nettype none
module cbp_parity
  import cbp_pkg::*;
(
  input wire logic [AD_W-1:0] ad,
  input wire logic [CBE_W-1:0] cbe,
  output logic par
);
  // Parity bit makes the count of ones across all 37 lines even
  always_comb begin
    par = ^{ad, cbe}; // [RULE4]
  end
endmodule
`default_nettype wire

// ==== hw/cbp_sync.sv ====
// Two-flop synchroniser for one level or toggle
`default_nettype none
module cbp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ==== hw/cbp_top.sv ====
// Card bus command/byte-enable lane handling with parity generation and checking
`default_nettype none
module cbp_top
  import cbp_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic LINK_CLK,
  input wire logic [AD_W-1:0] LINK_AD_I,
  output logic [AD_W-1:0] LINK_AD_O,
  output logic LINK_AD_OE,
  input wire logic [CBE_W-1:0] LINK_CBE_N_I,
  output logic [CBE_W-1:0] LINK_CBE_N_O,
  output logic LINK_CBE_OE,
  input wire logic LINK_PAR_I,
  output logic LINK_PAR_O,
  output logic LINK_PAR_OE,
  input wire logic LINK_FRAME_N_I,
  output logic LINK_FRAME_N_O,
  output logic LINK_FRAME_OE,
  input wire logic REQ,
  input wire logic [CBE_W-1:0] REQ_CMD,
  input wire logic [AD_W-1:0] REQ_ADDR,
  input wire logic [CBE_W-1:0] REQ_BE,
  input wire logic [AD_W-1:0] REQ_WDATA,
  output logic BUSY,
  output logic DONE,
  output logic [AD_W-1:0] RDATA,
  output logic TGT_VALID,
  output logic [CBE_W-1:0] TGT_CMD,
  output logic [AD_W-1:0] TGT_ADDR,
  output logic [AD_W-1:0] TGT_DATA,
  output logic [CBE_W-1:0] TGT_BE,
  input wire logic PAR_ERR_CLR,
  output logic PAR_ERR
);

  ////////////////////////////////////////////////////////////////////////////
  // Request side, system clock

  logic [CBE_W-1:0] hold_cmd, next_hold_cmd;
  logic [AD_W-1:0] hold_addr, next_hold_addr;
  logic [CBE_W-1:0] hold_be, next_hold_be;
  logic [AD_W-1:0] hold_wdata, next_hold_wdata;
  logic req_tgl, next_req_tgl;
  logic busy, next_busy;
  logic done, next_done;
  logic [AD_W-1:0] rdata, next_rdata;
  logic ack_s, ack_d, next_ack_d;
  logic ack_tgl;
  logic [AD_W-1:0] link_rdata;

  // Held words stay still from the request toggle to the acknowledge, so the
  // link side may sample them directly
  always_comb begin
    next_hold_cmd = hold_cmd;
    next_hold_addr = hold_addr;
    next_hold_be = hold_be;
    next_hold_wdata = hold_wdata;
    next_req_tgl = req_tgl;
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    next_ack_d = ack_s;
    if (REQ && !busy) begin
      next_hold_cmd = REQ_CMD;
      next_hold_addr = REQ_ADDR;
      next_hold_be = REQ_BE;
      next_hold_wdata = REQ_WDATA;
      next_req_tgl = !req_tgl;
      next_busy = 1'b1;
    end
    if (ack_s != ack_d) begin
      next_busy = 1'b0;
      next_done = 1'b1;
      next_rdata = link_rdata;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_cmd <= CBE_RST;
      hold_addr <= AD_RST;
      hold_be <= CBE_RST;
      hold_wdata <= AD_RST;
      req_tgl <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= AD_RST;
      ack_d <= 1'b0;
    end else begin
      hold_cmd <= next_hold_cmd;
      hold_addr <= next_hold_addr;
      hold_be <= next_hold_be;
      hold_wdata <= next_hold_wdata;
      req_tgl <= next_req_tgl;
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
      ack_d <= next_ack_d;
    end
  end

  assign BUSY = busy;
  assign DONE = done;
  assign RDATA = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Initiator sequencer, link clock

  logic req_s, req_d, next_req_d;
  cbp_ini_type state, next_state;
  logic [AD_W-1:0] ad_o, next_ad_o;
  logic ad_oe, next_ad_oe;
  logic [CBE_W-1:0] cbe_o, next_cbe_o;
  logic cbe_oe, next_cbe_oe;
  logic frame_o, next_frame_o;
  logic frame_oe, next_frame_oe;
  logic next_ack_tgl;
  logic [AD_W-1:0] next_link_rdata;
  logic is_write;

  cbp_sync u_req_sync (.clk(LINK_CLK), .rst(RST), .d(req_tgl), .q(req_s));
  cbp_sync u_ack_sync (.clk(CLK), .rst(RST), .d(ack_tgl), .q(ack_s));

  assign is_write = hold_cmd[CMD_DIR_BIT];

  // One address phase and one data phase with no wait states
  always_comb begin
    next_state = state;
    next_req_d = req_d;
    next_ad_o = ad_o;
    next_ad_oe = 1'b0;
    next_cbe_o = cbe_o;
    next_cbe_oe = 1'b0;
    next_frame_o = FRAME_N_RST;
    next_frame_oe = 1'b0;
    next_ack_tgl = ack_tgl;
    next_link_rdata = link_rdata;
    case (state)
      INI_IDLE: begin
        // A card cycle already framed on the bus keeps the request waiting
        if (req_s != req_d && LINK_FRAME_N_I) begin
          next_req_d = req_s;
          next_state = INI_ADDR;
          next_ad_o = hold_addr;
          next_ad_oe = 1'b1;
          next_cbe_o = hold_cmd; // [RULE1]
          next_cbe_oe = 1'b1;
          next_frame_o = 1'b0;
          next_frame_oe = 1'b1;
        end
      end
      INI_ADDR: begin
        next_state = INI_DATA;
        next_ad_o = hold_wdata;
        next_ad_oe = is_write;
        next_cbe_o = ~hold_be; // [RULE2]
        next_cbe_oe = 1'b1;
        next_frame_o = 1'b1;
        next_frame_oe = 1'b1;
      end
      INI_DATA: begin
        next_state = INI_PAR;
        if (!is_write) begin
          next_link_rdata = LINK_AD_I;
        end
      end
      INI_PAR: begin
        next_state = INI_IDLE;
        next_ack_tgl = !ack_tgl;
      end
      default: begin
        next_state = INI_IDLE;
      end
    endcase
  end

  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      state <= INI_IDLE;
      req_d <= 1'b0;
      ad_o <= AD_RST;
      ad_oe <= 1'b0;
      cbe_o <= CBE_RST;
      cbe_oe <= 1'b0;
      frame_o <= FRAME_N_RST;
      frame_oe <= 1'b0;
      ack_tgl <= 1'b0;
      link_rdata <= AD_RST;
    end else begin
      state <= next_state;
      req_d <= next_req_d;
      ad_o <= next_ad_o;
      ad_oe <= next_ad_oe;
      cbe_o <= next_cbe_o;
      cbe_oe <= next_cbe_oe;
      frame_o <= next_frame_o;
      frame_oe <= next_frame_oe;
      ack_tgl <= next_ack_tgl;
      link_rdata <= next_link_rdata;
    end
  end

  assign LINK_AD_O = ad_o;
  assign LINK_AD_OE = ad_oe;
  assign LINK_CBE_N_O = cbe_o;
  assign LINK_CBE_OE = cbe_oe;
  assign LINK_FRAME_N_O = frame_o;
  assign LINK_FRAME_OE = frame_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Parity generation and checking, link clock

  logic bus_par;
  logic par_o, next_par_o;
  logic par_oe, next_par_oe;
  logic chk_valid, next_chk_valid;
  logic chk_par, next_chk_par;
  logic perr_tgl, next_perr_tgl;
  logic mismatch;
  logic tgt_phase;

  // Parity is taken from the wires, so it covers whichever party drove them
  cbp_parity u_bus_par (.ad(LINK_AD_I), .cbe(LINK_CBE_N_I), .par(bus_par));

  assign mismatch = chk_valid && (chk_par != LINK_PAR_I); // [RULE6]

  always_comb begin
    // Parity follows our own driven phase by one card clock
    next_par_o = ^{ad_o, cbe_o}; // [RULE4] [RULE5]
    next_par_oe = ad_oe; // [RULE5]
    next_chk_par = bus_par; // [RULE4]
    next_chk_valid = tgt_phase;
    next_perr_tgl = perr_tgl;
    if (mismatch) begin
      next_perr_tgl = !perr_tgl; // [RULE7]
    end
  end

  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      par_o <= PAR_RST;
      par_oe <= 1'b0;
      chk_valid <= 1'b0;
      chk_par <= PAR_RST;
      perr_tgl <= 1'b0;
    end else begin
      par_o <= next_par_o;
      par_oe <= next_par_oe;
      chk_valid <= next_chk_valid;
      chk_par <= next_chk_par;
      perr_tgl <= next_perr_tgl;
    end
  end

  assign LINK_PAR_O = par_o;
  assign LINK_PAR_OE = par_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Target capture, link clock

  logic frame_d, next_frame_d;
  logic tgt_data, next_tgt_data;
  logic [CBE_W-1:0] tgt_cmd, next_tgt_cmd;
  logic [AD_W-1:0] tgt_addr, next_tgt_addr;
  logic [AD_W-1:0] tgt_word, next_tgt_word;
  logic [CBE_W-1:0] tgt_be, next_tgt_be;
  logic tgt_tgl, next_tgt_tgl;
  logic [AD_W-1:0] lane_word;
  logic tgt_addr_ph;

  assign tgt_addr_ph = (state == INI_IDLE) && !frame_oe && !LINK_FRAME_N_I && frame_d;
  assign tgt_phase = tgt_addr_ph || tgt_data;

  // Lanes whose enable is off read as zero
  for (genvar n = 0; n < CBE_W; n++) begin : g_lane
    assign lane_word[n*LANE_W +: LANE_W] =
      LINK_CBE_N_I[n] ? {LANE_W{1'b0}} : LINK_AD_I[n*LANE_W +: LANE_W]; // [RULE3]
  end

  always_comb begin
    next_frame_d = LINK_FRAME_N_I;
    next_tgt_data = tgt_addr_ph;
    next_tgt_cmd = tgt_cmd;
    next_tgt_addr = tgt_addr;
    next_tgt_word = tgt_word;
    next_tgt_be = tgt_be;
    next_tgt_tgl = tgt_tgl;
    if (tgt_addr_ph) begin
      next_tgt_cmd = LINK_CBE_N_I; // [RULE1]
      next_tgt_addr = LINK_AD_I;
    end
    if (tgt_data && tgt_cmd[CMD_DIR_BIT]) begin
      next_tgt_word = lane_word; // [RULE2] [RULE3]
      next_tgt_be = ~LINK_CBE_N_I;
      next_tgt_tgl = !tgt_tgl;
    end
  end

  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      frame_d <= FRAME_N_RST;
      tgt_data <= 1'b0;
      tgt_cmd <= CBE_RST;
      tgt_addr <= AD_RST;
      tgt_word <= AD_RST;
      tgt_be <= CBE_RST;
      tgt_tgl <= 1'b0;
    end else begin
      frame_d <= next_frame_d;
      tgt_data <= next_tgt_data;
      tgt_cmd <= next_tgt_cmd;
      tgt_addr <= next_tgt_addr;
      tgt_word <= next_tgt_word;
      tgt_be <= next_tgt_be;
      tgt_tgl <= next_tgt_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target results and parity error status, system clock

  logic tgt_s, tgt_d, next_tgt_d;
  logic perr_s, perr_d, next_perr_d;
  logic tvalid, next_tvalid;
  logic [CBE_W-1:0] tcmd, next_tcmd;
  logic [AD_W-1:0] taddr, next_taddr;
  logic [AD_W-1:0] tdata, next_tdata;
  logic [CBE_W-1:0] tbe, next_tbe;
  logic perr, next_perr;

  cbp_sync u_tgt_sync (.clk(CLK), .rst(RST), .d(tgt_tgl), .q(tgt_s));
  cbp_sync u_perr_sync (.clk(CLK), .rst(RST), .d(perr_tgl), .q(perr_s));

  // Target words are held only until the next target write; two target
  // writes closer than about three system clocks may be seen as the later one alone
  always_comb begin
    next_tgt_d = tgt_s;
    next_perr_d = perr_s;
    next_tvalid = 1'b0;
    next_tcmd = tcmd;
    next_taddr = taddr;
    next_tdata = tdata;
    next_tbe = tbe;
    next_perr = perr && !PAR_ERR_CLR;
    if (tgt_s != tgt_d) begin
      next_tvalid = 1'b1;
      next_tcmd = tgt_cmd;
      next_taddr = tgt_addr;
      next_tdata = tgt_word;
      next_tbe = tgt_be;
    end
    if (perr_s != perr_d) begin
      next_perr = 1'b1; // [RULE7]
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tgt_d <= 1'b0;
      perr_d <= 1'b0;
      tvalid <= 1'b0;
      tcmd <= CBE_RST;
      taddr <= AD_RST;
      tdata <= AD_RST;
      tbe <= CBE_RST;
      perr <= 1'b0;
    end else begin
      tgt_d <= next_tgt_d;
      perr_d <= next_perr_d;
      tvalid <= next_tvalid;
      tcmd <= next_tcmd;
      taddr <= next_taddr;
      tdata <= next_tdata;
      tbe <= next_tbe;
      perr <= next_perr;
    end
  end

  assign TGT_VALID = tvalid;
  assign TGT_CMD = tcmd;
  assign TGT_ADDR = taddr;
  assign TGT_DATA = tdata;
  assign TGT_BE = tbe;
  assign PAR_ERR = perr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_addr_phase;
    state == INI_ADDR && cbe_oe;
  endsequence

  sequence s_data_phase;
    state == INI_DATA && cbe_oe;
  endsequence

  chk_cmd_on_addr: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE1]
    s_addr_phase |-> LINK_CBE_N_O == hold_cmd && LINK_AD_O == hold_addr)
    else $error("address phase lacks command or address");

  chk_be_on_data: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE2]
    s_addr_phase ##1 s_data_phase |-> LINK_CBE_N_O == ~hold_be)
    else $error("data phase lacks byte enables");

  chk_lane_zero: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE3]
    (tgt_data && tgt_cmd[CMD_DIR_BIT] && LINK_CBE_N_I[2]) |=> tgt_word[23:16] == 8'h00)
    else $error("disabled lane not cleared");

  chk_even_parity: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE4]
    par_oe |-> ^{$past(ad_o), $past(cbe_o), LINK_PAR_O} == 1'b0)
    else $error("driven parity not even");

  chk_parity_delay: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE5]
    s_addr_phase |=> LINK_PAR_OE ##0 s_data_phase)
    else $error("parity not one card clock after address");

  chk_mismatch_flag: assert property (@(posedge LINK_CLK) disable iff (RST) // [RULE6]
    (tgt_phase ##1 (LINK_PAR_I != $past(bus_par))) |=> perr_tgl != $past(perr_tgl))
    else $error("target parity mismatch missed");

  chk_err_sticky: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
    (perr_s != perr_d) |=> PAR_ERR ##1 (PAR_ERR || $past(PAR_ERR_CLR)))
    else $error("parity error not held");

  chk_err_clear: assert property (@(posedge CLK) disable iff (RST) // [RULE7]
    (PAR_ERR && PAR_ERR_CLR && perr_s == perr_d) |=> !PAR_ERR)
    else $error("parity error not cleared");

endmodule
`default_nettype wire

// ==== sim/cbp_card.sv ====
// Card-side model: answers host cycles and starts its own writes
`default_nettype none
module cbp_card (
  input wire logic lclk,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic frame_n,
  input wire logic par,
  output logic [31:0] ad_o,
  output logic aoe,
  output logic [3:0] cbe_o,
  output logic fr_o,
  output logic ioe,
  output logic par_o,
  output logic poe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rd = 32'h0;
  logic [31:0] adr;
  logic [31:0] dat;
  logic [3:0] cmd;
  logic [3:0] ben;
  int bad = 0;

  initial begin
    ad_o = 32'h0;
    aoe = 1'b0;
    cbe_o = 4'h0;
    fr_o = 1'b1;
    ioe = 1'b0;
    par_o = 1'b0;
    poe = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Target side of host-initiated cycles
  initial forever begin
    @(posedge lclk);
    if (!frame_n && !ioe) begin
      adr = ad;
      cmd = cbe;
      #1 aoe = !cmd[0];
      ad_o = rd;
      @(posedge lclk);
      dat = ad;
      ben = cbe;
      if (par !== ^{adr, cmd}) bad++;
      #1 aoe = 1'b0;
      par_o = ^{rd, ben};
      poe = !cmd[0];
      @(posedge lclk);
      if (cmd[0] && par !== ^{dat, ben}) bad++;
      #1 poe = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Card as initiator; e flips parity to provoke a mismatch
  task automatic wr(input logic [31:0] a, d, input logic [3:0] c, bn, input logic e);
    @(posedge lclk) #1;
    ioe = 1'b1;
    aoe = 1'b1;
    fr_o = 1'b0;
    ad_o = a;
    cbe_o = c;
    @(posedge lclk) #1;
    fr_o = 1'b1;
    ad_o = d;
    cbe_o = bn;
    par_o = ^{a, c} ^ e;
    poe = 1'b1;
    @(posedge lclk) #1;
    ioe = 1'b0;
    aoe = 1'b0;
    par_o = ^{d, bn} ^ e;
    @(posedge lclk) #1;
    poe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the card bus command, byte-enable and parity block
`default_nettype none
module testbench;
  import cbp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rst = 1'b1, lclk = 1'b0, req = 1'b0, clr = 1'b0;
  logic [3:0] r_cmd = 4'h0, r_be = 4'h0, cbe_o, cbe_w, c_cbe, t_cmd, t_be;
  logic [31:0] r_adr = 32'h0, r_wd = 32'h0, ad_o, ad_w, c_ad, rdata, t_adr, t_dat;
  logic [31:0] idle = 32'h0;
  logic ad_oe, cbe_oe, par_o, par_oe, fr_o, fr_oe, par_w, fr_w, c_aoe, c_ioe, c_par, c_poe, c_fr;
  logic busy, done, t_vld, perr;
  int err_total = 0;
  int tests_run = 0;

  initial forever #5 clk = ~clk;
  initial #3 forever #32 lclk = ~lclk;
  // Released address/data and command lines above bit 0 wander so a stale value can never be mistaken for data; bit 0 and parity stay low
  always @(posedge lclk) idle <= ~idle ^ 32'h1;
  assign ad_w = ad_oe ? ad_o : c_aoe ? c_ad : idle;
  assign cbe_w = cbe_oe ? cbe_o : c_ioe ? c_cbe : idle[3:0];
  assign par_w = par_oe ? par_o : c_poe ? c_par : idle[0];
  assign fr_w = fr_oe ? fr_o : c_ioe ? c_fr : 1'b1;

  cbp_top i_cbp_top (.CLK(clk), .RST(rst), .LINK_CLK(lclk), .LINK_AD_I(ad_w), .LINK_AD_O(ad_o),
    .LINK_AD_OE(ad_oe), .LINK_CBE_N_I(cbe_w), .LINK_CBE_N_O(cbe_o), .LINK_CBE_OE(cbe_oe),
    .LINK_PAR_I(par_w), .LINK_PAR_O(par_o), .LINK_PAR_OE(par_oe), .LINK_FRAME_N_I(fr_w),
    .LINK_FRAME_N_O(fr_o), .LINK_FRAME_OE(fr_oe), .REQ(req), .REQ_CMD(r_cmd), .REQ_ADDR(r_adr),
    .REQ_BE(r_be), .REQ_WDATA(r_wd), .BUSY(busy), .DONE(done), .RDATA(rdata), .TGT_VALID(t_vld),
    .TGT_CMD(t_cmd), .TGT_ADDR(t_adr), .TGT_DATA(t_dat), .TGT_BE(t_be), .PAR_ERR_CLR(clr),
    .PAR_ERR(perr));
  cbp_card i_cbp_card (.lclk(lclk), .ad(ad_w), .cbe(cbe_w), .frame_n(fr_w), .par(par_w),
    .ad_o(c_ad), .aoe(c_aoe), .cbe_o(c_cbe), .fr_o(c_fr), .ioe(c_ioe), .par_o(c_par), .poe(c_poe));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wait_hi(ref logic s, input int n);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(posedge clk) #1;
      k++;
      if (k > n) begin
        chk(1'b0, "timeout");
        print_verdict();
      end
    end
  endtask

  task automatic host(input logic [3:0] c, be, input logic [31:0] a, d);
    r_cmd = c;
    r_be = be;
    r_adr = a;
    r_wd = d;
    req = 1'b1;
    @(posedge clk) #1;
    req = 1'b0;
    chk(busy === 1'b1, "busy missing");
    wait_hi(done, 200);
    chk(i_cbp_card.adr === a && i_cbp_card.cmd === c, "command phase");
    chk(i_cbp_card.ben === ~be, "byte enables");
    if (c[0]) chk(i_cbp_card.dat === d, "write data");
    else chk(rdata === i_cbp_card.rd, "read data");
    chk(i_cbp_card.bad == 0, "host parity");
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_cmds;
    for (int i = 0; i < 16; i++) begin
      i_cbp_card.rd = {8{i[3:0]}} ^ 32'hA5C3_0F96;
      host(i[3:0], i[3:0] ^ 4'h9, {24'h80_0000, i[5:0], 2'b00}, 32'h1234_5678 ^ {8{i[3:0]}});
    end
    $display("test cmds done");
  endtask

  task automatic t_tgt;
    logic [3:0] bes [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hF};
    logic [31:0] m;
    logic seen = 1'b0;
    foreach (bes[i]) begin
      m = {{8{bes[i][3]}}, {8{bes[i][2]}}, {8{bes[i][1]}}, {8{bes[i][0]}}};
      fork
        i_cbp_card.wr(32'h4000_0010, 32'hDEAD_BEEF, 4'h7, ~bes[i], 1'b0);
        wait_hi(t_vld, 60);
      join
      chk(t_adr === 32'h4000_0010 && t_cmd === 4'h7, "target command");
      chk(t_be === bes[i] && t_dat === (32'hDEAD_BEEF & m), "target lanes");
    end
    // A card read is not answered and must not report a target word
    fork
      i_cbp_card.wr(32'h4000_0030, 32'h0000_0000, 4'h6, 4'h0, 1'b0);
      repeat (40) @(posedge clk) #1 if (t_vld === 1'b1) seen = 1'b1;
    join
    chk(seen === 1'b0, "target read answered");
    repeat (8) @(posedge clk);
    #1 chk(perr === 1'b0, "false parity error");
    $display("test target done");
  endtask

  task automatic t_perr;
    fork
      i_cbp_card.wr(32'h4000_0020, 32'h0F0F_0F0F, 4'h7, 4'h0, 1'b1);
      wait_hi(perr, 80);
    join
    repeat (8) @(posedge clk);
    #1 chk(perr === 1'b1, "parity error not sticky");
    clr = 1'b1;
    @(posedge clk) #1;
    clr = 1'b0;
    @(posedge clk) #1;
    chk(perr === 1'b0, "parity error not cleared");
    $display("test parity error done");
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    // Reset spans two edges of the slower link clock as well
    repeat (2) @(posedge lclk);
    @(posedge clk) #1 rst = 1'b0;
    chk(ad_oe === 1'b0 && cbe_oe === 1'b0 && par_oe === 1'b0 && fr_oe === 1'b0, "reset enables");
    chk(fr_o === 1'b1 && busy === 1'b0 && done === 1'b0 && perr === 1'b0, "reset outputs");
    t_cmds();
    t_tgt();
    t_perr();
    print_verdict();
  end
endmodule
`default_nettype wire
